// file: sza_access_ctrl.sv
// Security state, zone gating, fuses and antitearing sequencing
`timescale 1ns/1ps
`default_nettype none
module sza_access_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic nv_done,
  input wire logic tear_pending_nv,
  output logic [2:0] nv_op,
  output logic [7:0] nv_addr,
  output logic xfer_pwd_encrypted,
  output logic xfer_data_encrypted,
  output logic xfer_use_mac
);
  import sza_pkg::*;

  typedef enum logic [2:0] {SZA_T_IDLE, SZA_T_DIRECT, SZA_T_BUF, SZA_T_COPY,
    SZA_T_RESTORE} sza_tear_e;

  sza_mode_e mode;
  sza_tear_e tstate;
  logic [1:0] auth_set;
  logic pwd_active;
  logic pwd_write;
  logic [1:0] pwd_set;
  logic [SZA_NUM_FUSES-1:0] fuse;
  logic tear_en;
  logic por_checked;
  logic [31:0] zone_cfg;
  logic res_granted;
  logic res_nack;
  logic [3:0] res_reason;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [8:0] locked;
  // Decoded write request
  logic wr_fire;
  logic [2:0] ev_op;
  logic ev_ok;
  logic [1:0] ev_set;
  logic ev_wr;
  logic ev_fire;
  logic acc_fire;
  logic cnt_ok;
  logic cnt_fail;
  logic [3:0] cnt_idx;
  // Access request fields
  logic [1:0] a_zone;
  logic a_write;
  logic a_cfg;
  logic a_enc;
  logic [7:0] a_addr;
  logic [4:0] a_len;
  logic [7:0] a_data;
  logic [7:0] a_lock;
  logic [7:0] zc;
  logic wl_allow;
  logic wl_nack;
  logic next_granted;
  logic next_nack;
  logic [3:0] next_reason;

  // Field layout of the access register
  assign a_zone = w_data[1:0];
  assign a_write = w_data[2];
  assign a_cfg = w_data[3];
  assign a_enc = w_data[4];
  assign a_len = w_data[12:8];
  assign a_addr = w_data[23:16];
  assign a_data = w_data[31:24];
  assign a_lock = zone_cfg[31:24] & 8'h00 | lock_src(w_data);
  assign zc = zone_cfg[8*a_zone +: 8];

  // Current lock byte travels in bits 7:5 and 15:13 of the access word; its bits 1:0 read as ones
  function automatic logic [7:0] lock_src(input logic [31:0] d);
    lock_src = {d[7:5], d[15:13], 2'b11} & 8'hFF;
  endfunction

  // Page boundary test used for antitearing length limit
  function automatic logic crosses_page(input logic [7:0] addr, input logic [4:0] len);
    logic [5:0] last;
    last = {3'h0, addr[2:0]} + {1'b0, len} - 6'h1;
    crosses_page = (len == 5'h0) || (last >= 6'(SZA_PAGE_BYTES));
  endfunction

  sza_wlock_check u_wlock (
    .lock_byte(a_lock),
    .offset(a_addr[2:0]),
    .new_byte(a_data),
    .len(a_len),
    .allow(wl_allow),
    .nack(wl_nack)
  );

  sza_attempt_counters #(.NUM(SZA_NUM_PWD + 1), .LIMIT(SZA_TRY_LIMIT)) u_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .idx(cnt_idx),
    .ok(cnt_ok),
    .fail(cnt_fail),
    .locked(locked)
  );

  // AXI write channel: address and data taken in either order
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == SZA_OFS_CTRL || aw_addr == SZA_OFS_ZONE_CFG ||
          aw_addr == SZA_OFS_EVENT || aw_addr == SZA_OFS_ACCESS) begin
        s_axi_bresp <= 2'b00;
      end else begin
        s_axi_bresp <= 2'b10;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Event decode; strobes ignored for command registers
  assign ev_fire = wr_fire && aw_addr == SZA_OFS_EVENT;
  assign acc_fire = wr_fire && aw_addr == SZA_OFS_ACCESS;
  assign ev_op = w_data[2:0];
  assign ev_set = w_data[5:4];
  assign ev_wr = w_data[6];
  assign ev_ok = w_data[8];
  assign cnt_idx = (ev_op == SZA_EV_AUTH) ? 4'(SZA_CNT_AUTH) : {1'b0, ev_set, ev_wr};
  assign cnt_ok = ev_fire && ev_ok && (ev_op == SZA_EV_AUTH || ev_op == SZA_EV_PWD);
  assign cnt_fail = ev_fire && !ev_ok && (ev_op == SZA_EV_AUTH || ev_op == SZA_EV_PWD);

  // Communication security mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= SZA_STD;
      auth_set <= 2'h0;
    end else if (ev_fire) begin
      if (ev_op == SZA_EV_AUTH) begin
        // Starting an attempt discards the old result either way
        if (ev_ok && !locked[SZA_CNT_AUTH]) begin
          mode <= SZA_AUTH;
          auth_set <= ev_set;
        end else begin
          mode <= SZA_STD;
        end
      end else if (ev_op == SZA_EV_ENC && mode != SZA_STD) begin
        if (ev_ok) mode <= SZA_ENC;
        else mode <= SZA_AUTH;
      end else if (ev_op == SZA_EV_MAC_BAD) begin
        mode <= SZA_STD;
      end else if (ev_op == SZA_EV_RELEASE) begin
        mode <= SZA_STD;
      end
    end
  end

  // Single active password register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwd_active <= 1'b0;
      pwd_write <= 1'b0;
      pwd_set <= 2'h0;
    end else if (ev_fire) begin
      if (ev_op == SZA_EV_PWD) begin
        // A new presentation replaces the old one, good or bad
        pwd_active <= ev_ok && !locked[cnt_idx];
        pwd_write <= ev_wr;
        pwd_set <= ev_set;
      end else if (ev_op == SZA_EV_RELEASE) begin
        pwd_active <= 1'b0;
      end
    end
  end

  // Control, zone config and fuses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tear_en <= 1'b0;
      fuse <= '0;
      zone_cfg <= 32'h0000_0000;
    end else if (wr_fire && aw_addr == SZA_OFS_CTRL && s_axi_wstrb[0]) begin
      tear_en <= w_data[0];
      // Fuses only accumulate; fuse i needs fuse i-1 blown or its bit set in the same write; several may blow at once
      for (int i = 0; i < SZA_NUM_FUSES; i++) begin
        if (w_data[1+i] && (i == 0 || fuse[i-1] || w_data[i])) fuse[i] <= 1'b1;
      end
    end else if (wr_fire && aw_addr == SZA_OFS_ZONE_CFG) begin
      for (int b = 0; b < 4; b++) begin
        if (s_axi_wstrb[b]) zone_cfg[8*b +: 8] <= w_data[8*b +: 8];
      end
    end
  end

  // Access decision for one read or write request
  always_comb begin
    next_granted = 1'b1;
    next_nack = 1'b0;
    next_reason = SZA_RS_OK;
    if (tstate != SZA_T_IDLE) begin
      next_granted = 1'b0;
      next_reason = SZA_RS_BUSY;
    end else if (a_cfg) begin
      // Fuse k freezes config quarter k, fuse 2 also quarter 3; rights are fixed logic
      if (a_write && fuse[a_addr[7:6] > 2'h2 ? 2'h2 : a_addr[7:6]]) begin
        next_granted = 1'b0;
        next_reason = SZA_RS_FUSE;
      end
    end else begin
      if ((zc[SZA_ZF_PWD_RD] && !a_write && !(pwd_active &&
          pwd_set == zc[SZA_ZF_SET +: 2])) || (zc[SZA_ZF_PWD_WR] && a_write &&
          !(pwd_active && pwd_write && pwd_set == zc[SZA_ZF_SET +: 2]))) begin
        next_granted = 1'b0;
        next_reason = SZA_RS_RIGHTS;
      end else if (zc[SZA_ZF_AUTH] && (mode == SZA_STD ||
          auth_set != zc[SZA_ZF_SET +: 2])) begin
        next_granted = 1'b0;
        next_reason = SZA_RS_RIGHTS;
      end else if (zc[SZA_ZF_ENC] && !(mode == SZA_ENC && a_enc)) begin
        next_granted = 1'b0;
        next_reason = SZA_RS_RIGHTS;
      end else if (a_write && zc[SZA_ZF_WLOCK] && !wl_allow) begin
        next_granted = 1'b0;
        next_nack = wl_nack;
        next_reason = SZA_RS_WLOCK;
      end else if (a_write && tear_en && crosses_page(a_addr, a_len)) begin
        next_granted = 1'b0;
        next_reason = SZA_RS_TEAR;
      end
    end
  end

  // Result register holds the last decision
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_granted <= 1'b0;
      res_nack <= 1'b0;
      res_reason <= SZA_RS_OK;
    end else if (acc_fire) begin
      res_granted <= next_granted;
      res_nack <= next_nack;
      res_reason <= next_reason;
    end
  end

  // Non-volatile write sequencer with antitearing and recovery
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tstate <= SZA_T_IDLE;
      por_checked <= 1'b0;
      nv_op <= SZA_NV_NONE;
      nv_addr <= 8'h00;
    end else begin
      case (tstate)
        SZA_T_IDLE: begin
          if (!por_checked) begin
            por_checked <= 1'b1;
            if (tear_pending_nv) begin
              tstate <= SZA_T_RESTORE;
              nv_op <= SZA_NV_RESTORE;
            end
          end else if (acc_fire && next_granted && a_write) begin
            nv_addr <= a_addr;
            if (tear_en) begin
              tstate <= SZA_T_BUF;
              nv_op <= SZA_NV_BUF;
            end else begin
              tstate <= SZA_T_DIRECT;
              nv_op <= SZA_NV_DIRECT;
            end
          end
        end
        SZA_T_BUF: begin
          if (nv_done) begin
            tstate <= SZA_T_COPY;
            nv_op <= SZA_NV_COPY;
          end
        end
        SZA_T_DIRECT, SZA_T_COPY, SZA_T_RESTORE: begin
          if (nv_done) begin
            tstate <= SZA_T_IDLE;
            nv_op <= SZA_NV_NONE;
          end
        end
        default: begin
          tstate <= SZA_T_IDLE;
          nv_op <= SZA_NV_NONE;
        end
      endcase
    end
  end

  // Transport protection per mode; config data gets no separate setting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xfer_pwd_encrypted <= 1'b0;
      xfer_data_encrypted <= 1'b0;
      xfer_use_mac <= 1'b0;
    end else begin
      xfer_pwd_encrypted <= (mode != SZA_STD);
      xfer_data_encrypted <= (mode == SZA_ENC);
      xfer_use_mac <= (mode != SZA_STD);
    end
  end

  // AXI read channel, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        if (s_axi_araddr == SZA_OFS_CTRL) begin
          s_axi_rdata <= {28'h0, fuse, tear_en};
        end else if (s_axi_araddr == SZA_OFS_STATUS) begin
          s_axi_rdata <= {12'h0, locked, tstate, pwd_set, pwd_write, pwd_active,
            auth_set, mode};
        end else if (s_axi_araddr == SZA_OFS_ZONE_CFG) begin
          s_axi_rdata <= zone_cfg;
        end else if (s_axi_araddr == SZA_OFS_RESULT) begin
          s_axi_rdata <= {26'h0, res_reason, res_nack, res_granted};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // sza_access_ctrl
`default_nettype wire

// file: sza_pkg.sv
// Shared constants for the secure zone access control block
package sza_pkg;
  // Register byte offsets
  localparam logic [7:0] SZA_OFS_CTRL = 8'h00;
  localparam logic [7:0] SZA_OFS_STATUS = 8'h04;
  localparam logic [7:0] SZA_OFS_ZONE_CFG = 8'h08;
  localparam logic [7:0] SZA_OFS_EVENT = 8'h0C;
  localparam logic [7:0] SZA_OFS_ACCESS = 8'h10;
  localparam logic [7:0] SZA_OFS_RESULT = 8'h14;
  // Sizes
  localparam int SZA_CFG_BITS = 2048;
  localparam int SZA_CFG_BYTES = SZA_CFG_BITS / 8;
  localparam int SZA_NUM_FUSES = 3;
  localparam int SZA_NUM_ZONES = 4;
  localparam int SZA_NUM_PWD = 8;
  localparam int SZA_CNT_AUTH = 8;
  localparam int SZA_TRY_LIMIT = 4;
  localparam int SZA_PAGE_BYTES = 8;
  // Zone config fields, one byte per zone
  localparam int SZA_ZF_PWD_RD = 0;
  localparam int SZA_ZF_PWD_WR = 1;
  localparam int SZA_ZF_AUTH = 2;
  localparam int SZA_ZF_ENC = 3;
  localparam int SZA_ZF_WLOCK = 4;
  localparam int SZA_ZF_SET = 5;
  // Event opcodes
  localparam logic [2:0] SZA_EV_AUTH = 3'h1;
  localparam logic [2:0] SZA_EV_ENC = 3'h2;
  localparam logic [2:0] SZA_EV_PWD = 3'h3;
  localparam logic [2:0] SZA_EV_MAC_BAD = 3'h4;
  localparam logic [2:0] SZA_EV_RELEASE = 3'h5;
  // Refusal reasons
  localparam logic [3:0] SZA_RS_OK = 4'h0;
  localparam logic [3:0] SZA_RS_BUSY = 4'h1;
  localparam logic [3:0] SZA_RS_FUSE = 4'h2;
  localparam logic [3:0] SZA_RS_RIGHTS = 4'h3;
  localparam logic [3:0] SZA_RS_TEAR = 4'h4;
  localparam logic [3:0] SZA_RS_WLOCK = 4'h5;
  // Non-volatile operation codes
  localparam logic [2:0] SZA_NV_NONE = 3'h0;
  localparam logic [2:0] SZA_NV_DIRECT = 3'h1;
  localparam logic [2:0] SZA_NV_BUF = 3'h2;
  localparam logic [2:0] SZA_NV_COPY = 3'h3;
  localparam logic [2:0] SZA_NV_RESTORE = 3'h4;
  typedef enum logic [1:0] {SZA_STD, SZA_AUTH, SZA_ENC} sza_mode_e;
endpackage

// file: sza_attempt_counters.sv
// Failed-attempt counters, one per password plus one for authentication
`timescale 1ns/1ps
`default_nettype none
module sza_attempt_counters #(
  parameter int NUM = 9,
  parameter int LIMIT = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] idx,
  input wire logic ok,
  input wire logic fail,
  output logic [NUM-1:0] locked
);
  import sza_pkg::*;
  logic [2:0] cnt [NUM];

  // Count failures, clear on success below the limit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM; i++) cnt[i] <= 3'h0;
    end else begin
      for (int i = 0; i < NUM; i++) begin
        if (int'(idx) == i && cnt[i] < 3'(LIMIT)) begin
          if (fail) cnt[i] <= cnt[i] + 3'h1;
          else if (ok) cnt[i] <= 3'h0;
        end
      end
    end
  end

  // Saturated counters refuse every further try
  always_comb begin
    for (int i = 0; i < NUM; i++) locked[i] = (cnt[i] >= 3'(LIMIT));
  end
endmodule // sza_attempt_counters
`default_nettype wire

// file: sza_wlock_check.sv
// Write-lock page check for one byte write
`timescale 1ns/1ps
`default_nettype none
module sza_wlock_check (
  input wire logic [7:0] lock_byte,
  input wire logic [2:0] offset,
  input wire logic [7:0] new_byte,
  input wire logic [4:0] len,
  output logic allow,
  output logic nack
);
  import sza_pkg::*;
  // Offset 0 is the lock byte itself; it may only lose ones
  always_comb begin
    nack = (len != 5'h1);
    if (offset == 3'h0) begin
      allow = lock_byte[0] && ((new_byte & ~lock_byte) == 8'h00);
    end else begin
      allow = lock_byte[offset];
    end
    if (nack) allow = 1'b0;
  end
endmodule // sza_wlock_check
`default_nettype wire

// file: sza_nv_model.sv
// Behavioural model of the non-volatile store behind the sequencer
`timescale 1ns/1ps
`default_nettype none
module sza_nv_model #(
  parameter int LAT = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] nv_op,
  input wire logic tear_in,
  output logic nv_done,
  output logic tear_pending_nv
);
  import sza_pkg::*;
  int cnt;
  // Each operation finishes LAT+1 cycles after it appears, done is one pulse
  always_ff @(posedge aclk) begin
    if (!aresetn || nv_op == SZA_NV_NONE || nv_done) begin
      cnt <= 0;
      nv_done <= 1'b0;
    end else if (cnt == LAT) begin
      nv_done <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Torn-copy flag survives reset, as real storage would, until restored
  // One process owns the flag, so its power-on value needs no second driver
  initial begin
    tear_pending_nv = 1'b0;
    forever begin
      @(posedge aclk);
      if (tear_in)
        tear_pending_nv <= 1'b1;
      else if (nv_op == SZA_NV_RESTORE && nv_done)
        tear_pending_nv <= 1'b0;
    end
  end
endmodule // sza_nv_model
`default_nettype wire

// file: sza_access_ctrl_properties.sv
// Temporal checks on the access controller ports
`timescale 1ns/1ps
`default_nettype none
module sza_ctrl_props
  import sza_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic nv_done,
  input wire logic tear_pending_nv,
  input wire logic [2:0] nv_op,
  input wire logic xfer_pwd_encrypted,
  input wire logic xfer_data_encrypted,
  input wire logic xfer_use_mac
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Steps of a torn-safe write
  sequence s_buf_done;
    nv_op == SZA_NV_BUF && nv_done;
  endsequence
  sequence s_copy_done;
    nv_op == SZA_NV_COPY && nv_done;
  endsequence
  AST_BUF_TO_COPY: assert property (s_buf_done |=> nv_op == SZA_NV_COPY)
    else $error("buffer write not followed by copy");
  AST_COPY_TO_IDLE: assert property (s_copy_done |=> nv_op == SZA_NV_NONE)
    else $error("copy not followed by idle");
  AST_NV_HOLD: assert property (nv_op != SZA_NV_NONE && !nv_done |=> $stable(nv_op))
    else $error("nv operation changed before done");
  AST_RESTORE: assert property ($rose(aresetn) && tear_pending_nv |-> ##[1:3] nv_op == SZA_NV_RESTORE)
    else $error("torn copy not restored after reset");
  AST_NO_RESTORE: assert property ($rose(aresetn) && !tear_pending_nv |-> (nv_op != SZA_NV_RESTORE)[*4])
    else $error("restore without torn copy");
  AST_STD_AT_START: assert property ($rose(aresetn) |-> (!xfer_pwd_encrypted && !xfer_data_encrypted && !xfer_use_mac)[*2])
    else $error("crypto active after reset");
  AST_PWD_MAC: assert property (xfer_use_mac == xfer_pwd_encrypted)
    else $error("password cipher and mac disagree");
  AST_DATA_ENC: assert property (xfer_data_encrypted |-> xfer_pwd_encrypted)
    else $error("data encrypted without password cipher");
  AST_ENC_VIA_AUTH: assert property ($rose(xfer_data_encrypted) |-> $past(xfer_pwd_encrypted))
    else $error("encryption entered without prior authentication");
  AST_AUTH_FIRST: assert property ($rose(xfer_pwd_encrypted) |-> !xfer_data_encrypted)
    else $error("encryption entered straight from standard mode");
endmodule // sza_ctrl_props
`default_nettype wire

// file: secure_zone_access_control_tb.sv
// Self-checking bench for the zone access controller
`timescale 1ns/1ps
`default_nettype none
module secure_zone_access_control_tb;
  import sza_pkg::*;
  logic aclk, aresetn, tear_in, nv_done, tear_pending_nv;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic xfer_pwd_encrypted, xfer_data_encrypted, xfer_use_mac;
  logic [7:0] s_axi_awaddr, s_axi_araddr, nv_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] nv_op;
  int err_count, total_checks;
  sza_access_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .nv_done, .tear_pending_nv, .nv_op, .nv_addr,
    .xfer_pwd_encrypted, .xfer_data_encrypted, .xfer_use_mac);
  sza_nv_model #(.LAT(3)) u_nv (.aclk, .aresetn, .nv_op, .tear_in, .nv_done, .tear_pending_nv);
  // Free-running clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic check(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Bus master: ready lines held high, so a response is taken when seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic ev(input logic [2:0] op, input logic [1:0] st, input logic w, ok);
    wr(SZA_OFS_EVENT, {23'h0, ok, 1'b0, w, st, 1'b0, op});
  endtask
  task automatic mode(input sza_mode_e m);
    rd(SZA_OFS_STATUS);
    check("mode", {30'h0, v[1:0]}, {30'h0, m});
  endtask
  function automatic logic [31:0] aw(input logic [1:0] z, input logic w, c,
    input logic [7:0] lk, input logic [4:0] n, input logic [7:0] ad, nb);
    return {nb, ad, lk[4:2], n, lk[7:5], 1'b0, c, w, z};
  endfunction
  // Access request, then its verdict; waits out any store it started
  task automatic acc(input logic [31:0] w, input logic [5:0] e);
    wr(SZA_OFS_ACCESS, w);
    rd(SZA_OFS_RESULT);
    check("result", {26'h0, v[5:0]}, {26'h0, e});
    while (nv_op !== SZA_NV_NONE) @(posedge aclk);
  endtask
  task automatic t_start;
    rd(SZA_OFS_STATUS);
    check("status", v, 32'h0);
    rd(8'h18);
    check("rd_unmapped", {30'h0, r}, 32'h2);
    wr(SZA_OFS_STATUS, 32'hF);
    check("wr_readonly", {30'h0, r}, 32'h2);
    $display("test start done");
  endtask
  task automatic t_modes;
    ev(SZA_EV_ENC, 2'h0, 1'b0, 1'b1);
    mode(SZA_STD);
    ev(SZA_EV_AUTH, 2'h0, 1'b0, 1'b1);
    mode(SZA_AUTH);
    check("xfer", {29'h0, xfer_pwd_encrypted, xfer_data_encrypted, xfer_use_mac}, 32'h5);
    ev(SZA_EV_ENC, 2'h0, 1'b0, 1'b1);
    mode(SZA_ENC);
    check("xfer", {29'h0, xfer_pwd_encrypted, xfer_data_encrypted, xfer_use_mac}, 32'h7);
    ev(SZA_EV_MAC_BAD, 2'h0, 1'b0, 1'b1);
    mode(SZA_STD);
    ev(SZA_EV_AUTH, 2'h0, 1'b0, 1'b1);
    ev(SZA_EV_ENC, 2'h0, 1'b0, 1'b0);
    mode(SZA_AUTH);
    ev(SZA_EV_AUTH, 2'h0, 1'b0, 1'b0);
    mode(SZA_STD);
    ev(SZA_EV_AUTH, 2'h1, 1'b0, 1'b1);
    ev(SZA_EV_RELEASE, 2'h0, 1'b0, 1'b1);
    mode(SZA_STD);
    $display("test modes done");
  endtask
  // Write password of set 1 owns counter 3, shown at status bit 14
  task automatic t_tries;
    ev(SZA_EV_AUTH, 2'h1, 1'b0, 1'b1);
    repeat (3) ev(SZA_EV_PWD, 2'h1, 1'b1, 1'b0);
    ev(SZA_EV_PWD, 2'h1, 1'b1, 1'b1);
    rd(SZA_OFS_STATUS);
    check("tries", {22'h0, v[19:11], v[4]}, {22'h0, 9'h000, 1'b1});
    repeat (3) ev(SZA_EV_PWD, 2'h1, 1'b1, 1'b0);
    rd(SZA_OFS_STATUS);
    check("tries", {22'h0, v[19:11], v[4]}, {22'h0, 9'h000, 1'b0});
    ev(SZA_EV_PWD, 2'h1, 1'b1, 1'b0);
    ev(SZA_EV_PWD, 2'h1, 1'b1, 1'b1);
    rd(SZA_OFS_STATUS);
    check("tries", {22'h0, v[19:11], v[4]}, {22'h0, 9'h008, 1'b0});
    $display("test tries done");
  endtask
  task automatic t_zone;
    wr(SZA_OFS_ZONE_CFG, 32'h08000003);
    acc(aw(2'd0, 1'b0, 1'b0, 8'hFF, 5'd1, 8'h10, 8'h00), {SZA_RS_RIGHTS, 2'b00});
    ev(SZA_EV_AUTH, 2'h0, 1'b0, 1'b1);
    ev(SZA_EV_PWD, 2'h0, 1'b1, 1'b1);
    acc(aw(2'd0, 1'b0, 1'b0, 8'hFF, 5'd1, 8'h10, 8'h00), {SZA_RS_OK, 2'b01});
    acc(aw(2'd0, 1'b1, 1'b0, 8'hFF, 5'd1, 8'h10, 8'hAA), {SZA_RS_OK, 2'b01});
    ev(SZA_EV_RELEASE, 2'h0, 1'b0, 1'b1);
    acc(aw(2'd0, 1'b0, 1'b0, 8'hFF, 5'd1, 8'h10, 8'h00), {SZA_RS_RIGHTS, 2'b00});
    acc(aw(2'd3, 1'b0, 1'b0, 8'hFF, 5'd1, 8'h10, 8'h00), {SZA_RS_RIGHTS, 2'b00});
    ev(SZA_EV_AUTH, 2'h0, 1'b0, 1'b1);
    ev(SZA_EV_ENC, 2'h0, 1'b0, 1'b1);
    // Encrypted-only zone also wants the command itself flagged as encrypted
    acc(aw(2'd3, 1'b0, 1'b0, 8'hFF, 5'd1, 8'h10, 8'h00) | 32'h10, {SZA_RS_OK, 2'b01});
    ev(SZA_EV_RELEASE, 2'h0, 1'b0, 1'b1);
    $display("test zone done");
  endtask
  // Lock byte D8 with bits 1:0 forced high locks page bytes 2 and 5
  task automatic t_wlock;
    s_axi_wstrb <= 4'h2;
    wr(SZA_OFS_ZONE_CFG, 32'h00001000);
    s_axi_wstrb <= 4'hF;
    rd(SZA_OFS_ZONE_CFG);
    check("zone_cfg", v, 32'h08001003);
    acc(aw(2'd1, 1'b1, 1'b0, 8'hD8, 5'd2, 8'h43, 8'h00), {SZA_RS_WLOCK, 2'b10});
    acc(aw(2'd1, 1'b1, 1'b0, 8'hD8, 5'd1, 8'h42, 8'h00), {SZA_RS_WLOCK, 2'b00});
    acc(aw(2'd1, 1'b1, 1'b0, 8'hD8, 5'd1, 8'h45, 8'h00), {SZA_RS_WLOCK, 2'b00});
    acc(aw(2'd1, 1'b1, 1'b0, 8'hD8, 5'd1, 8'h43, 8'h00), {SZA_RS_OK, 2'b01});
    acc(aw(2'd1, 1'b1, 1'b0, 8'hD8, 5'd1, 8'h40, 8'hFF), {SZA_RS_WLOCK, 2'b00});
    acc(aw(2'd1, 1'b1, 1'b0, 8'hD8, 5'd1, 8'h40, 8'hD2), {SZA_RS_OK, 2'b01});
    $display("test wlock done");
  endtask
  task automatic t_tear;
    logic [2:0] q[$];
    wr(SZA_OFS_CTRL, 32'h1);
    acc(aw(2'd2, 1'b1, 1'b0, 8'hFF, 5'd9, 8'h20, 8'h00), {SZA_RS_TEAR, 2'b00});
    wr(SZA_OFS_ACCESS, aw(2'd2, 1'b1, 1'b0, 8'hFF, 5'd8, 8'h20, 8'h00));
    repeat (40) begin
      @(posedge aclk);
      if (nv_op != SZA_NV_NONE && (q.size() == 0 || q[$] != nv_op)) q.push_back(nv_op);
      if (nv_op == SZA_NV_COPY) v[7:0] = nv_addr;
    end
    check("nv_seq", {26'h0, q.size() == 2 ? {q[0], q[1]} : 6'h3F},
      {26'h0, SZA_NV_BUF, SZA_NV_COPY});
    check("nv_addr", {24'h0, v[7:0]}, 32'h20);
    wr(SZA_OFS_CTRL, 32'h0);
    $display("test tear done");
  endtask
  task automatic t_restore;
    int n;
    tear_in <= 1'b1;
    @(posedge aclk);
    tear_in <= 1'b0;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    n = 0;
    while (nv_op !== SZA_NV_RESTORE && n < 10) begin
      @(posedge aclk);
      n++;
    end
    check("restore", {29'h0, nv_op}, {29'h0, SZA_NV_RESTORE});
    while (nv_op !== SZA_NV_NONE) @(posedge aclk);
    $display("test restore done");
  endtask
  // Fuse i blows only once fuse i-1 is blown or requested in the same write, and a write never clears it
  task automatic t_fuse;
    wr(SZA_OFS_CTRL, 32'h4);
    rd(SZA_OFS_CTRL);
    check("fuse", v, 32'h0);
    wr(SZA_OFS_CTRL, 32'h2);
    wr(SZA_OFS_CTRL, 32'h0);
    rd(SZA_OFS_CTRL);
    check("fuse", v, 32'h2);
    acc(aw(2'd0, 1'b1, 1'b1, 8'hFF, 5'd1, 8'h10, 8'h00), {SZA_RS_FUSE, 2'b00});
    acc(aw(2'd0, 1'b1, 1'b1, 8'hFF, 5'd1, 8'h50, 8'h00), {SZA_RS_OK, 2'b01});
    wr(SZA_OFS_CTRL, 32'hC);
    rd(SZA_OFS_CTRL);
    check("fuse", v, 32'hE);
    $display("test fuse done");
  endtask
  // Main sequence
  initial begin
    aresetn = 1'b0;
    tear_in = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_start;
    t_modes;
    t_tries;
    t_zone;
    t_wlock;
    t_tear;
    t_restore;
    t_fuse;
    stop_test;
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    stop_test;
  end
endmodule // secure_zone_access_control_tb
bind sza_access_ctrl sza_ctrl_props u_props (.aclk, .aresetn, .nv_done, .tear_pending_nv,
  .nv_op, .xfer_pwd_encrypted, .xfer_data_encrypted, .xfer_use_mac);
`default_nettype wire
